// ### hdl/ser_params.svh
// constants for the serial eeprom target
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH
// device type code: value is arbitrary, pick the one the system expects
`define SER_TYPE_CODE 4'h6
`define SER_ADDR_W 13
`define SER_PAGE_BITS 5
`define SER_CLK_MHZ 40
`define SER_WRITE_CYCLE_US 5000
`define SER_WRITE_CYCLE_CYC (`SER_WRITE_CYCLE_US * `SER_CLK_MHZ)
`define SER_PROT_TOP 2'h3
`endif

// ### hdl/ser_pkg.sv
// types for the serial eeprom target
package ser_pkg;
  typedef enum logic [6:0] {
    SER_IDLE = 7'h01,
    SER_DEV = 7'h02,
    SER_AHI = 7'h04,
    SER_ALO = 7'h08,
    SER_WDATA = 7'h10,
    SER_RDATA = 7'h20,
    SER_PROG = 7'h40
  } ser_state_t;
endpackage

// ### hdl/ser_eeprom.sv
// serial eeprom two-wire target with internal array and write buffer
`timescale 1ns/1ps
`include "ser_params.svh"
module ser_eeprom #(
  parameter int WRITE_CYCLES = `SER_WRITE_CYCLE_CYC,
  parameter int PAGE_BYTES = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_2,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_0,
  input wire logic write_protect,
  output logic write_busy
);
  localparam int AW = `SER_ADDR_W;
  localparam int PB = `SER_PAGE_BITS;

  logic [7:0] mem [0:(1 << AW) - 1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] page_vld_reg;

  // two-flop synchronisers; the first stage feeds only the second
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [2:0] strap_s1_reg, strap_s2_reg;
  logic wp_s1_reg, wp_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else if (clk_en) begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      strap_s1_reg <= {chip_select_strap_2, chip_select_strap_1,
                       chip_select_strap_0};
      strap_s2_reg <= strap_s1_reg;
      wp_s1_reg <= write_protect;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  ser_pkg::ser_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0] ahi_reg;
  logic ack_phase_reg;
  logic acked_reg;
  logic master_ack_reg;
  logic got_data_reg;
  logic [31:0] prog_cnt_reg;
  logic [PB-1:0] drain_idx_reg;

  wire [7:0] rx_byte = {shift_reg[6:0], sda_s2_reg};
  wire dev_match = rx_byte[7:4] == `SER_TYPE_CODE &&
                   rx_byte[3:1] == strap_s2_reg;
  wire byte_done = scl_rise && bit_cnt_reg == 4'h7;
  wire ninth_rise = scl_rise && bit_cnt_reg == 4'h8;
  wire in_prog = state_reg == ser_pkg::SER_PROG;
  wire [AW-1:0] addr_inc = addr_reg + 1'b1;
  wire [AW-1:0] addr_page_inc = {addr_reg[AW-1:PB],
                                 addr_reg[PB-1:0] + 1'b1};
  wire [AW-1:0] drain_addr = {addr_reg[AW-1:PB], drain_idx_reg};
  wire drain_prot = wp_s2_reg &&
                    drain_addr[AW-1:AW-2] == `SER_PROT_TOP;
  wire [7:0] rd_byte = mem[addr_reg];

  // buffered page bytes go to the array only at the end of the write cycle
  always_ff @(posedge clk_sys) begin
    if (clk_en && in_prog && prog_cnt_reg == 32'h0 &&
        page_vld_reg[drain_idx_reg] && !drain_prot) begin
      mem[drain_addr] <= page_buf[drain_idx_reg];
    end
    if (clk_en && state_reg == ser_pkg::SER_WDATA && byte_done) begin
      page_buf[addr_reg[PB-1:0]] <= rx_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ser_pkg::SER_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= '0;
      ahi_reg <= 8'h00;
      ack_phase_reg <= 1'b0;
      acked_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      got_data_reg <= 1'b0;
      prog_cnt_reg <= 32'h0;
      drain_idx_reg <= '0;
      page_vld_reg <= '0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      write_busy <= 1'b0;
    end else if (clk_en) begin
      if (in_prog) begin
        // inputs ignored; drain one buffered byte per cycle after the delay
        sda_oe <= 1'b0;
        if (prog_cnt_reg != 32'h0) begin
          prog_cnt_reg <= prog_cnt_reg - 32'h1;
        end else begin
          drain_idx_reg <= drain_idx_reg + 1'b1;
          if (drain_idx_reg == {PB{1'b1}}) begin
            page_vld_reg <= '0;
            write_busy <= 1'b0;
            state_reg <= ser_pkg::SER_IDLE;
          end
        end
      end else if (stop_det) begin
        sda_oe <= 1'b0;
        if (state_reg == ser_pkg::SER_WDATA && got_data_reg) begin
          // stop after a whole acked byte launches programming
          state_reg <= ser_pkg::SER_PROG;
          prog_cnt_reg <= 32'(WRITE_CYCLES);
          drain_idx_reg <= '0;
          write_busy <= 1'b1;
        end else begin
          state_reg <= ser_pkg::SER_IDLE;
          page_vld_reg <= '0;
        end
      end else if (start_det) begin
        state_reg <= ser_pkg::SER_DEV;
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe <= 1'b0;
        got_data_reg <= 1'b0;
        page_vld_reg <= '0;
      end else if (state_reg != ser_pkg::SER_IDLE) begin
        if (scl_rise) begin
          // the ninth bit is the ack slot; keep it out of the byte so the
          // direction bit is still in bit 0 when the address is decoded
          if (bit_cnt_reg < 4'h8) begin
            shift_reg <= rx_byte;
          end
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (ninth_rise) begin
            master_ack_reg <= ~sda_s2_reg;
          end
        end
        if (byte_done) begin
          acked_reg <= 1'b1;
          case (state_reg)
            ser_pkg::SER_DEV: begin
              acked_reg <= dev_match;
            end
            ser_pkg::SER_AHI: begin
              ahi_reg <= rx_byte;
            end
            ser_pkg::SER_ALO: begin
              addr_reg <= {ahi_reg[AW-9:0], rx_byte};
            end
            ser_pkg::SER_WDATA: begin
              page_vld_reg[addr_reg[PB-1:0]] <= 1'b1;
              addr_reg <= addr_page_inc;
            end
            ser_pkg::SER_RDATA: begin
              acked_reg <= 1'b0;
            end
            default: begin
              acked_reg <= 1'b0;
            end
          endcase
        end
        if (scl_fall) begin
          if (bit_cnt_reg == 4'h8 && acked_reg) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b1;
          end else if (bit_cnt_reg == 4'h9) begin
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
            case (state_reg)
              ser_pkg::SER_DEV: begin
                if (!acked_reg) begin
                  state_reg <= ser_pkg::SER_IDLE;
                end else if (shift_reg[0]) begin
                  state_reg <= ser_pkg::SER_RDATA;
                  shift_reg <= rd_byte;
                  addr_reg <= addr_inc;
                  sda_out <= rd_byte[7];
                  sda_oe <= ~rd_byte[7];
                end else begin
                  state_reg <= ser_pkg::SER_AHI;
                end
              end
              ser_pkg::SER_AHI: state_reg <= ser_pkg::SER_ALO;
              ser_pkg::SER_ALO: state_reg <= ser_pkg::SER_WDATA;
              ser_pkg::SER_WDATA: got_data_reg <= 1'b1;
              ser_pkg::SER_RDATA: begin
                if (master_ack_reg) begin
                  shift_reg <= rd_byte;
                  addr_reg <= addr_inc;
                  sda_out <= rd_byte[7];
                  sda_oe <= ~rd_byte[7];
                end else begin
                  state_reg <= ser_pkg::SER_IDLE;
                end
              end
              default: state_reg <= ser_pkg::SER_IDLE;
            endcase
          end else if (state_reg == ser_pkg::SER_RDATA) begin
            // open-drain: drive low for a zero, release for a one
            sda_out <= 1'b0;
            sda_oe <= bit_cnt_reg < 4'h8 ? ~shift_reg[7] : 1'b0;
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ### verif/ser_eeprom_asserts.sv
// checker for the serial eeprom target pins
`timescale 1ns/1ps
module ser_eeprom_asserts #(
  parameter int WRITE_CYCLES = 200,
  parameter int PAGE_BYTES = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy
);
  logic p_scl_reg, p_sda_reg, p_oe_reg;
  logic [3:0] age_reg;
  logic [2:0] ack_reg;
  int busy_reg;
  wire start_seen = scl_in && p_scl_reg && p_sda_reg && !sda_in;
  wire stop_seen = scl_in && p_scl_reg && !p_sda_reg && sda_in;
  wire ack_up = sda_oe && !p_oe_reg && ack_reg != 3'h7;
  wire age_up = age_reg != 4'hf;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      p_scl_reg <= 1'b1;
      p_sda_reg <= 1'b1;
      p_oe_reg <= 1'b0;
      age_reg <= 4'hf;
      ack_reg <= 3'h0;
      busy_reg <= 0;
    end else begin
      p_scl_reg <= scl_in;
      p_sda_reg <= sda_in;
      p_oe_reg <= sda_oe;
      age_reg <= stop_seen ? 4'h0 : age_reg + {3'h0, age_up};
      ack_reg <= start_seen ? 3'h0 : ack_reg + {2'h0, ack_up};
      busy_reg <= write_busy ? busy_reg + 1 : 0;
    end
  end
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("device drives data high");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !$past(scl_in))
    else $error("data pin moved while clock high");
  a_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("answer during write cycle");
  a_busy_after_stop: assert property (
    $rose(write_busy) |-> age_reg <= 4'h8)
    else $error("write cycle without stop");
  a_busy_min: assert property (
    $rose(write_busy) |-> write_busy[*8])
    else $error("write cycle too short");
  a_busy_len: assert property (
    $fell(write_busy) |-> busy_reg >= WRITE_CYCLES)
    else $error("write cycle ended early");
  a_busy_bound: assert property (
    busy_reg <= WRITE_CYCLES + PAGE_BYTES)
    else $error("write cycle never ends");
  a_write_needs_data: assert property (
    $rose(write_busy) |-> ack_reg >= 3'h4)
    else $error("write cycle without data byte");
  c_write: cover property ($rose(write_busy));
  c_ack: cover property ($rose(sda_oe) && !write_busy);
  c_stop: cover property (stop_seen);
endmodule
bind ser_eeprom ser_eeprom_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES), .PAGE_BYTES(PAGE_BYTES)
) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy)
);

// ### verif/ser_master.sv
// two-wire bus master model, open-drain data, clock idles high
`timescale 1ns/1ps
module ser_master (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // data only moves mid-low so the target never sees a false start
  task automatic bit_io(input logic b, output logic r);
    pull <= !b;
    q(2);
    scl <= 1'b1;
    q(2);
    r = sda;
    q(2);
    scl <= 1'b0;
    q(2);
  endtask
  task automatic start();
    pull <= 1'b0;
    q(2);
    scl <= 1'b1;
    q(4);
    pull <= 1'b1;
    q(4);
    scl <= 1'b0;
    q(2);
  endtask
  task automatic stop();
    pull <= 1'b1;
    q(2);
    scl <= 1'b1;
    q(4);
    pull <= 1'b0;
    q(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!mack, r);
  endtask
endmodule

// ### verif/tb_top.sv
// top bench for the serial eeprom target
`timescale 1ns/1ps
`include "ser_params.svh"
module tb_top;
  logic clk_sys, dut_oe, dut_out, busy, scl, pull, k;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic [7:0] mem [0:8191];
  logic [12:0] ptr, a;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 32'hcb6dfbc7;
  wire sda = (dut_oe ? dut_out : 1'b1) && !pull;
  ser_eeprom #(.WRITE_CYCLES(200), .PAGE_BYTES(32)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out(dut_out), .sda_oe(dut_oe),
    .chip_select_strap_2(cs[2]), .chip_select_strap_1(cs[1]),
    .chip_select_strap_0(cs[0]), .write_protect(wp), .write_busy(busy));
  ser_master m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .pull(pull));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {`SER_TYPE_CODE, cs, rd};
  endfunction
  task automatic send(input logic [7:0] d, input logic e);
    m.wbyte(d, k);
    chk("ack", {7'h0, k}, {7'h0, e});
  endtask
  task automatic addr(input logic [12:0] wa);
    logic [2:0] junk;
    junk = 3'($random(seed));
    m.start();
    send(dev(1'b0), 1'b1);
    send({junk, wa[12:8]}, 1'b1);
    send(wa[7:0], 1'b1);
    ptr = wa;
  endtask
  task automatic poll();
    m.start();
    m.wbyte(dev(1'b0), k);
    m.stop();
  endtask
  task automatic wr(input logic [12:0] wa, input int n);
    logic [7:0] d;
    addr(wa);
    repeat (n) begin
      d = 8'($random(seed));
      send(d, 1'b1);
      if (!(wp && ptr[12:11] == `SER_PROT_TOP)) mem[ptr] = d;
      ptr[4:0] = ptr[4:0] + 5'h1;
    end
    m.stop();
    repeat (4) @(posedge clk_sys);
    chk("busy", {7'h0, busy}, 8'h1);
    poll();
    chk("poll", {7'h0, k}, 8'h0);
    for (int i = 0; i < 20 && !k; i++) begin
      poll();
    end
    chk("ready", {6'h0, k, busy}, 8'h2);
  endtask
  task automatic rd(input int n);
    logic [7:0] d;
    m.start();
    send(dev(1'b1), 1'b1);
    for (int i = 1; i <= n; i++) begin
      m.rbyte(i < n, d);
      chk("data", d, mem[ptr]);
      ptr++;
    end
    m.stop();
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end
  initial begin
    cs <= 3'($random(seed));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      a = 13'($random(seed));
      wr(a, 1);
      addr(a);
      rd(1);
    end
    $display("test byte write done");
    a = {8'($random(seed)), 5'h1e};
    wr(a, 34);
    rd(1);
    addr({a[12:5], 5'h0});
    rd(32);
    $display("test page wrap done");
    wr(13'h1fff, 1);
    wr(13'h0, 1);
    addr(13'h1fff);
    rd(2);
    $display("test read wrap done");
    wp <= 1'b1;
    wr(13'h1fff, 1);
    wr(13'h17ff, 1);
    addr(13'h1fff);
    rd(1);
    addr(13'h17ff);
    rd(1);
    wp <= 1'b0;
    $display("test protect done");
    addr(13'h17ff);
    m.stop();
    repeat (8) @(posedge clk_sys);
    chk("busy", {7'h0, busy}, 8'h0);
    rd(1);
    m.start();
    m.wbyte({`SER_TYPE_CODE, ~cs, 1'b0}, k);
    chk("foreign", {7'h0, k}, 8'h0);
    m.stop();
    $display("test abort and select done");
    end_of_test();
  end
endmodule
